/* File: sft_checker_asserts.sv */
`timescale 1ns/100ps
// watches the port 0 engine and the outbound side of both ports
module sft_checker
   import sft_pkg::*;
#(
   parameter int SPACING = MIN_SPACING_CHARS
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic node_turnaround_select,
   input wire logic [1:0] port_turnaround_bit,
   input wire logic [1:0] port_operational,
   input wire logic [1:0] char_sync,
   input wire logic [1:0] port_ready,
   input wire logic [1:0] rx_satp,
   input wire logic [ALLOW_W-1:0] hold_frame_allowance,
   input wire logic [ALLOW_W-1:0] idle_frame_allowance,
   input wire logic [1:0][XFER_W-1:0] outstanding_xfers,
   input wire logic [1:0] app_frame_pending,
   input wire sft_pkg::sft_tok_t [1:0] tx_token,
   input wire logic [1:0] app_originate_ok,
   input wire logic [1:0] sat_holding,
   input wire logic [1:0][CNT_W-1:0] originated_count
);
   // quotas scaled by outstanding transfers
   wire [CNT_W-1:0] hold_q = hold_frame_allowance * outstanding_xfers[0];
   wire [CNT_W-1:0] idle_q = idle_frame_allowance * outstanding_xfers[0];
   wire refl0 = node_turnaround_select | port_turnaround_bit[0] | ~&port_operational;
   logic [7:0] gap_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // cycles since last release, parked at all ones so the first release passes
   always_ff @(posedge clk)
      if (!rst_n) gap_r <= 8'hff;
      else if ($fell(sat_holding[0])) gap_r <= 8'h00;
      else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
   ////////////////////////////////////////////////////////////////////////////////
   property p_fwd;
      $fell(sat_holding[0]) && !$past(refl0) |-> tx_token[1] == SFT_TOK_SAT;
   endproperty
   a_fwd: assert property (p_fwd) else $error("forwarded token missing");
   property p_refl;
      $fell(sat_holding[0]) && $past(refl0) |-> tx_token[0] == SFT_TOK_SATP;
   endproperty
   a_refl: assert property (p_refl) else $error("returned token missing");
   property p_clr;
      $fell(sat_holding[0]) |-> originated_count[0] == '0;
   endproperty
   a_clr: assert property (p_clr) else $error("count not cleared");
   property p_space;
      $fell(sat_holding[0]) |-> gap_r >= SPACING - 1;
   endproperty
   a_space: assert property (p_space) else $error("releases too close");
   property p_ready;
      tx_token[1] != SFT_TOK_NONE |-> $past(port_ready[1]);
   endproperty
   a_ready: assert property (p_ready) else $error("token on unready port");
   property p_idle;
      originated_count[0] >= idle_q |-> !app_originate_ok[0];
   endproperty
   a_idle: assert property (p_idle) else $error("origination past idle quota");
   property p_gate;
      sat_holding[0] && app_frame_pending[0] && originated_count[0] < hold_q
         |-> app_originate_ok[0];
   endproperty
   a_gate: assert property (p_gate) else $error("holder not allowed to send");
   property p_satp;
      rx_satp[0] && char_sync[0] && node_turnaround_select && port_ready[0]
         |-> ##[1:10] tx_token[0] == SFT_TOK_SAT;
   endproperty
   a_satp: assert property (p_satp) else $error("returned token late");
   c_fwd: cover property ($fell(sat_holding[0]));
   c_refl: cover property (tx_token[0] == SFT_TOK_SATP);
   c_gate: cover property (sat_holding[0] && app_originate_ok[0]);
endmodule // sft_checker

bind sft_fairness_token sft_checker #(.SPACING(SPACING)) chk_u (
   .clk(clk), .rst_n(rst_n), .node_turnaround_select(node_turnaround_select),
   .port_turnaround_bit(port_turnaround_bit), .port_operational(port_operational),
   .char_sync(char_sync), .port_ready(port_ready), .rx_satp(rx_satp),
   .hold_frame_allowance(hold_frame_allowance), .idle_frame_allowance(idle_frame_allowance),
   .outstanding_xfers(outstanding_xfers), .app_frame_pending(app_frame_pending),
   .tx_token(tx_token), .app_originate_ok(app_originate_ok), .sat_holding(sat_holding),
   .originated_count(originated_count));

/* File: sft_dir_engine.sv */
`timescale 1ns/100ps
// one direction of the fairness algorithm: counter, quotas, hold state
module sft_dir_engine
   import sft_pkg::*;
#(
   parameter int SPACING = MIN_SPACING_CHARS,
   parameter int LOSS_CYC = TOKEN_LOSS_CYC
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ALLOW_W-1:0] hold_frame_allowance,
   input wire logic [ALLOW_W-1:0] idle_frame_allowance,
   input wire logic [XFER_W-1:0] outstanding_xfers,
   input wire logic sat_in,
   input wire logic app_frame_sent,
   input wire logic app_frame_pending,
   input wire logic cut_through_pending,
   input wire logic send_ok,
   input wire logic reflect,
   output logic holding,
   output logic release_now,
   output logic app_originate_ok,
   output logic [CNT_W-1:0] originated_count
);
   logic [CNT_W-1:0] hold_q;
   logic [CNT_W-1:0] idle_q;
   logic satisfied;
   logic [31:0] token_loss_timer_r;
   logic [7:0] space_r;
   logic sat_any;
   logic loss_fire;

   // allowances scale with concurrent transfers
   assign hold_q = CNT_W'(hold_frame_allowance * outstanding_xfers);
   assign idle_q = CNT_W'(idle_frame_allowance * outstanding_xfers);
   assign satisfied = (originated_count >= hold_q) || !app_frame_pending;
   assign loss_fire = (token_loss_timer_r >= 32'(LOSS_CYC - 1));
   assign sat_any = sat_in || loss_fire;
   // release once satisfied, spacing met and link ready; ready gates only send
   assign release_now = holding && satisfied && send_ok && (space_r == 8'h00);
   // origination gate, frame kinds other than application bypass this
   assign app_originate_ok = (holding && !satisfied) ||
      (!cut_through_pending && (idle_q > originated_count));

   // hold state; a second token while holding is dropped
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         holding <= 1'b0;
      else if (release_now)
         holding <= 1'b0;
      else if (sat_any)
         holding <= 1'b1;
   end

   // frame counter, zeroed on release, aborted frames never pulse sent
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         originated_count <= CNT_RESET;
      else if (release_now)
         originated_count <= CNT_RESET;
      else if (app_frame_sent && originated_count != {CNT_W{1'b1}})
         originated_count <= originated_count + 1'b1;
   end

   // token loss timer cleared on each forward or reflect as complement
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         token_loss_timer_r <= 32'h0;
      else if (release_now || loss_fire)
         token_loss_timer_r <= 32'h0;
      else
         token_loss_timer_r <= token_loss_timer_r + 32'h1;
   end

   // spacing since previous release; reflect flag is unused here
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         space_r <= 8'h00;
      else if (release_now)
         space_r <= 8'(SPACING - 1);
      else if (space_r != 8'h00)
         space_r <= space_r - 8'h01;
   end

   logic unused_reflect;
   assign unused_reflect = reflect;
endmodule // sft_dir_engine

/* File: sft_fairness_token.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - tokens pass to other port unless turnaround selected, then return same port
// - received SAT is held per fairness then sent out the other port
// - dual-port node forwards SAT' out the other port only if a SAT came on that other port since the previous SAT'
// - turned-back SAT is held then sent as SAT' on same port
// - turned-back SAT' becomes SAT on same port unconditionally
// - release SAT when satisfied, hold otherwise even awaiting ready, zero count
// - satisfied when count reaches hold allowance or nothing to originate
// - allowances are per-frame allowances times outstanding transfers
// - count only completed application frames, never aborted ones
// - privileged and control frames are never gated here
// - originate when holding and unsatisfied, or idle link and below idle allowance
// - below hold allowance: originate without cut-through, after SAT hold cut-through
// - between allowances: originate without cut-through, release SAT at once
// - at idle allowance: originate nothing, release SAT and zero count
// - accept tokens in any state with sync, transmit only when ready
// - string end returns SAT as SAT' once satisfied
// - string end returns SAT' as SAT immediately, count untouched
// - drop SAT' when no SAT came on other port since previous SAT'
// - port turnaround bit returns tokens on same port, routing unchanged
// - loss timer clears on release, at 100 ms creates a token
// - SAT received while holding one is discarded
// - each pass or return adds at most 10 character periods
// - at least 100 character periods between successive releases
// - two independent instances, one per traffic direction
module sft_fairness_token
   import sft_pkg::*;
#(
   parameter int LOSS_CYC = TOKEN_LOSS_CYC,
   parameter int SPACING = MIN_SPACING_CHARS
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic node_turnaround_select,
   input wire logic [1:0] port_turnaround_bit,
   input wire logic [1:0] port_operational,
   input wire logic [1:0] char_sync,
   input wire logic [1:0] port_ready,
   input wire logic [1:0] rx_sat,
   input wire logic [1:0] rx_satp,
   input wire logic [ALLOW_W-1:0] hold_frame_allowance,
   input wire logic [ALLOW_W-1:0] idle_frame_allowance,
   input wire logic [1:0][XFER_W-1:0] outstanding_xfers,
   input wire logic [1:0] app_frame_sent,
   input wire logic [1:0] app_frame_pending,
   input wire logic [1:0] cut_through_pending,
   output sft_tok_t [1:0] tx_token,
   output logic [1:0] app_originate_ok,
   output logic [1:0] sat_holding,
   output logic [1:0][CNT_W-1:0] originated_count
);
   import sft_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // routing decode

   // true when port p sends tokens back on itself
   function automatic logic turns(input logic [1:0] tb, input logic [1:0] op,
                                  input logic nts, input int p);
      turns = nts || tb[p] || !op[0] || !op[1];
   endfunction

   // outbound port of a token taken on port p
   function automatic logic dest_of(input logic turn, input int p);
      dest_of = turn ? 1'(p) : 1'(1 - p);
   endfunction

   logic both_op;
   logic [1:0] rel_dest;
   logic [1:0] satp_go;
   logic [1:0] slot_sat;
   logic [1:0] ret;
   logic [1:0] rel;
   logic [1:0] sat_acc;
   logic [1:0] satp_acc;
   logic [1:0] sat_seen_r;
   logic [1:0] satp_keep;
   logic [1:0] satp_pend_r;
   logic [1:0] satp_dest_r;
   sft_tok_t [1:0] tok_nxt;

   assign both_op = port_operational[0] && port_operational[1];
   // tokens are taken in any port state while sync holds
   assign sat_acc = rx_sat & char_sync;
   assign satp_acc = rx_satp & char_sync;

   ////////////////////////////////////////////////////////////////////////
   // one engine per receiving port, i.e. per traffic direction

   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_dir
         logic send_ok;
         logic slot_free;
         logic satp_yield;
         assign ret[p] = turns(port_turnaround_bit, port_operational,
                               node_turnaround_select, p);
         assign rel_dest[p] = dest_of(ret[p], p);
         // mixed turnaround bits can aim both engines at one port;
         // engine 0 wins, and a SAT' from port 0 beats one from port 1
         if (p == 0)
         begin : g_first
            assign slot_free = 1'b1;
            assign satp_yield = 1'b0;
         end
         else
         begin : g_second
            assign slot_free = !(rel[0] && (rel_dest[0] == rel_dest[1]));
            assign satp_yield = satp_go[0] && (satp_dest_r[0] == satp_dest_r[1]);
         end
         // outbound port must be ready before the token leaves
         assign send_ok = port_ready[rel_dest[p]] && slot_free;
         // a held SAT' waits for a ready port and a slot no release takes
         assign satp_go[p] = satp_pend_r[p] && port_ready[satp_dest_r[p]] &&
            !slot_sat[satp_dest_r[p]] && !satp_yield;
         assign slot_sat[p] = (rel[0] && (rel_dest[0] == 1'(p))) ||
            (rel[1] && (rel_dest[1] == 1'(p)));
         sft_dir_engine #(
            .SPACING(SPACING),
            .LOSS_CYC(LOSS_CYC)
         ) u_eng (
            .clk(clk),
            .rst_n(rst_n),
            .hold_frame_allowance(hold_frame_allowance),
            .idle_frame_allowance(idle_frame_allowance),
            .outstanding_xfers(outstanding_xfers[p]),
            .sat_in(sat_acc[p]),
            .app_frame_sent(app_frame_sent[p]),
            .app_frame_pending(app_frame_pending[p]),
            .cut_through_pending(cut_through_pending[p]),
            .send_ok(send_ok),
            .reflect(ret[p]),
            .holding(sat_holding[p]),
            .release_now(rel[p]),
            .app_originate_ok(app_originate_ok[p]),
            .originated_count(originated_count[p])
         );
         // drop stale complement token on a closed loop
         assign satp_keep[p] = ret[p] || !both_op || sat_seen_r[1-p];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // complement tracking

   // a SAT on port q arms the SAT' filter of the other port
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sat_seen_r <= 2'b00;
      else
         for (int q = 0; q < 2; q++)
            if (sat_acc[q])
               sat_seen_r[q] <= 1'b1;
            else if (satp_acc[1-q])
               sat_seen_r[q] <= 1'b0;
   end

   // SAT' wait for ready out-port, sent next idle slot, well within bound
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         satp_pend_r <= 2'b00;
         satp_dest_r <= 2'b00;
      end
      else
         for (int p = 0; p < 2; p++)
            if (satp_acc[p] && satp_keep[p])
            begin
               satp_pend_r[p] <= 1'b1;
               satp_dest_r[p] <= dest_of(ret[p], p);
            end
            else if (satp_go[p])
               satp_pend_r[p] <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit token choice, SAT release wins a shared slot

   always_comb
   begin
      tok_nxt = '{SFT_TOK_NONE, SFT_TOK_NONE};
      for (int p = 0; p < 2; p++)
      begin
         // SAT' returned becomes SAT, passed stays SAT'
         if (satp_go[p])
            tok_nxt[satp_dest_r[p]] = (satp_dest_r[p] == 1'(p)) ?
               SFT_TOK_SAT : SFT_TOK_SATP;
      end
      for (int p = 0; p < 2; p++)
      begin
         if (rel[p])
            tok_nxt[ret[p] ? p : 1 - p] = ret[p] ? SFT_TOK_SATP : SFT_TOK_SAT;
      end
   end

   // registered token out, one cycle after decision
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         tx_token <= '{SFT_TOK_NONE, SFT_TOK_NONE};
      else
         tx_token <= tok_nxt;
   end
endmodule // sft_fairness_token

/* File: sft_neighbour.sv */
`timescale 1ns/100ps
// neighbouring port: sends one token after a chosen lag
module sft_neighbour
(
   input wire logic clk,
   output logic rx_sat,
   output logic rx_satp
);
   initial
   begin
      rx_sat = 1'b0;
      rx_satp = 1'b0;
   end
   // one-character pulse, launched just after an edge
   task automatic send(input bit is_sat, input int lag);
      repeat (lag) @(posedge clk);
      // callers already stand just after an edge when no lag is asked
      if (lag > 0)
         #1;
      if (is_sat) rx_sat = 1'b1;
      else rx_satp = 1'b1;
      @(posedge clk);
      #1;
      rx_sat = 1'b0;
      rx_satp = 1'b0;
   endtask
endmodule // sft_neighbour

/* File: sft_pkg.sv */
package sft_pkg;
   // character clock at 25 MHz, one character per cycle
   localparam int CLK_HZ = 25000000;
   // token loss time-out in milliseconds
   localparam int TOKEN_LOSS_MS = 100;
   localparam int TOKEN_LOSS_CYC = (CLK_HZ / 1000) * TOKEN_LOSS_MS;
   // latency ceiling and spacing floor in character periods
   localparam int MAX_DELAY_CHARS = 10;
   localparam int MIN_SPACING_CHARS = 100;
   // widths of allowances, transfer count and frame counter
   localparam int ALLOW_W = 8;
   localparam int XFER_W = 4;
   localparam int CNT_W = ALLOW_W + XFER_W;
   localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
   // token kinds emitted on a port
   typedef enum logic [1:0] {SFT_TOK_NONE, SFT_TOK_SAT, SFT_TOK_SATP} sft_tok_t;
endpackage : sft_pkg

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import sft_pkg::*;
   localparam int LOSS = 2000;
   logic clk, rst_n, nts;
   logic [1:0] ptb, op, sync, rdy, rx_sat, rx_satp, sent, pend, cut, ok, holding;
   logic [ALLOW_W-1:0] hold_a, idle_a;
   logic [1:0][XFER_W-1:0] xf;
   sft_tok_t [1:0] tx_token;
   logic [1:0][CNT_W-1:0] cnt;
   logic [2:0] expq[$];
   int fail_count, checks_done, i, h, hq;
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   sft_fairness_token #(.LOSS_CYC(LOSS)) dut_u (.clk(clk), .rst_n(rst_n),
      .node_turnaround_select(nts), .port_turnaround_bit(ptb), .port_operational(op),
      .char_sync(sync), .port_ready(rdy), .rx_sat(rx_sat), .rx_satp(rx_satp),
      .hold_frame_allowance(hold_a), .idle_frame_allowance(idle_a), .outstanding_xfers(xf),
      .app_frame_sent(sent), .app_frame_pending(pend), .cut_through_pending(cut),
      .tx_token(tx_token), .app_originate_ok(ok), .sat_holding(holding),
      .originated_count(cnt));
   sft_neighbour nb0_u (.clk(clk), .rx_sat(rx_sat[0]), .rx_satp(rx_satp[0]));
   sft_neighbour nb1_u (.clk(clk), .rx_sat(rx_sat[1]), .rx_satp(rx_satp[1]));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] seen, input logic [15:0] want_v);
      checks_done++;
      if (seen !== want_v)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want_v);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task want(input int p, input sft_tok_t t);
      expq.push_back({p[0], t});
   endtask
   // reset also clears leftover timers so no stray token spoils a scenario
   task do_reset;
      rst_n = 1'b0;
      {nts, ptb, sent, pend, cut} = '0;
      {op, sync, rdy} = 6'h3f;
      hold_a = 8'h01;
      idle_a = 8'h04;
      xf = 8'h11;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
   endtask
   task drain;
      for (int k = 0; k < 400 && expq.size() > 0; k++) @(posedge clk);
      repeat (20) @(posedge clk);
      #1 chk(expq.size(), 0);
   endtask
   task frames(input int p, input int n);
      repeat (n)
      begin
         sent[p] = 1'b1;
         @(posedge clk);
         #1 sent[p] = 1'b0;
         @(posedge clk);
         #1;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // every token seen is matched against the oldest prediction
   always @(negedge clk)
      for (int p = 0; p < 2; p++)
         if (rst_n && tx_token[p] !== SFT_TOK_NONE)
            chk({p[0], tx_token[p]}, (expq.size() > 0) ? expq.pop_front() : 3'h7);
   initial
   begin
      #(40 * 30000);
      fail_count++;
      stop_test;
   end
   initial
   begin
      void'($urandom(44599));
      do_reset;
      want(1, SFT_TOK_SAT); nb0_u.send(1, 0); drain;
      for (i = 0; i < 2; i++)
      begin
         do_reset; nts = (i == 0); ptb = {2{i[0]}};
         want(0, SFT_TOK_SATP); nb0_u.send(1, 3); drain;
         want(0, SFT_TOK_SAT); nb0_u.send(0, 0); drain;
      end
      do_reset;
      want(0, SFT_TOK_SAT); nb1_u.send(1, 0); drain;
      want(1, SFT_TOK_SATP); nb0_u.send(0, 5); drain;
      nb0_u.send(0, 0); drain;
      do_reset; op = 2'b01; frames(0, 2);
      want(0, SFT_TOK_SAT); nb0_u.send(0, 0); drain; chk(cnt[0], 2);
      want(0, SFT_TOK_SATP); nb0_u.send(1, 0); drain; chk(cnt[0], 0);
      // held token waits for the hold quota, a second one is dropped
      do_reset; hold_a = 8'h02; idle_a = 8'h08; pend = 2'b01; cut = 2'b01;
      nb0_u.send(1, 0); repeat (5) @(posedge clk); #1 chk(holding[0], 1);
      chk(ok[0], 1);
      nb0_u.send(1, 0); frames(0, 1); chk(holding[0], 1);
      want(1, SFT_TOK_SAT); frames(0, 1); drain; chk(cnt[0], 0);
      pend = 2'b00; want(1, SFT_TOK_SAT); nb0_u.send(1, 0); drain;
      // no character sync, then outbound port not ready
      do_reset; sync = 2'b10; nb0_u.send(1, 0); repeat (5) @(posedge clk);
      #1 chk(holding[0], 0);
      sync = 2'b11; rdy = 2'b01; nb0_u.send(1, 0); repeat (30) @(posedge clk);
      #1 want(1, SFT_TOK_SAT); rdy = 2'b11; drain;
      // random quotas, idle never below hold
      do_reset; hold_a = 1 + $urandom % 3; idle_a = hold_a + $urandom % 4;
      xf[0] = 1 + $urandom % 3; pend = 2'b01; h = idle_a * xf[0]; hq = hold_a * xf[0];
      frames(0, hq); chk(ok[0], h > hq);
      cut = 2'b01; @(posedge clk); #1 chk(ok[0], 0);
      cut = 2'b00; frames(0, h - hq); chk(cnt[0], h);
      chk(ok[0], 0);
      want(1, SFT_TOK_SAT); nb0_u.send(1, 0); drain; chk(ok[0], 1);
      // lost tokens regenerate on both engines
      do_reset; want(0, SFT_TOK_SAT); want(1, SFT_TOK_SAT);
      repeat (LOSS + 20) @(posedge clk);
      drain;
      stop_test;
   end
endmodule // tb_top
